// ===== hdl/ufs_uart_status.sv
// UART FIFO status, level counters and FIFO test access behind APB
// Assumes the serial engines share CLOCK and give same-clock strobes
`timescale 1ns/1ps
module ufs_uart_status
    import ufs_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              RST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [31:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              RX_PUSH,
    input  wire logic [DATA_W-1:0] RX_DATA,
    input  wire logic              RX_ACTIVE,
    input  wire logic              TX_POP,
    input  wire logic              TX_ACTIVE,
    output logic      [DATA_W-1:0] TX_DATA,
    output logic                   TX_VALID,
    output logic                   IRQ
);
    // Control state
    logic              fifo_test_access_enable;
    logic              fifo_enable;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_enable;
    logic              prev_rx_full;
    logic              prev_tx_empty;
    logic              prev_rx_data;

    // FIFO wires
    logic [DATA_W-1:0] rx_head;
    logic [DATA_W-1:0] tx_head;
    ufs_lvl_t          rx_level;
    ufs_lvl_t          tx_level;
    logic              rx_full;
    logic              rx_empty;
    logic              tx_full;
    logic              tx_empty;
    logic              busy;

    // Bus decode
    wire setup_phase  = PSEL && !PENABLE;
    wire access_done  = PSEL && PENABLE && PREADY;
    wire wr_done      = access_done && PWRITE;
    wire rd_done      = access_done && !PWRITE;

    wire hit_data     = (PADDR == ADDR_DATA);
    wire hit_fctrl    = (PADDR == ADDR_FCTRL);
    wire hit_taccess  = (PADDR == ADDR_TACCESS);
    wire hit_status   = (PADDR == ADDR_STATUS);
    wire hit_tx_lvl   = (PADDR == ADDR_TX_LVL);
    wire hit_rx_lvl   = (PADDR == ADDR_RX_LVL);
    wire hit_test_dat = (PADDR == ADDR_TEST_DAT);
    wire hit_irq_stat = (PADDR == ADDR_IRQ_STAT);
    wire hit_irq_clr  = (PADDR == ADDR_IRQ_CLR);
    wire hit_irq_en   = (PADDR == ADDR_IRQ_EN);

    wire mapped = hit_data || hit_fctrl || hit_taccess || hit_status
               || hit_tx_lvl || hit_rx_lvl || hit_test_dat
               || hit_irq_stat || hit_irq_clr || hit_irq_en;

    // Write-only and read-only registers answer the wrong direction with an error
    wire dir_bad = (hit_irq_clr && !PWRITE)
                || ((hit_status || hit_tx_lvl || hit_rx_lvl || hit_irq_stat) && PWRITE);
    wire bad_access = !mapped || dir_bad;

    // Register writes
    wire wr_fctrl   = wr_done && hit_fctrl;
    wire wr_taccess = wr_done && hit_taccess && FIFO_ACCESS;
    wire wr_irq_clr = wr_done && hit_irq_clr;
    wire wr_irq_en  = wr_done && hit_irq_en;

    wire next_fifo_test_access_enable = wr_taccess ? PWDATA[TA_EN]
                                                   : fifo_test_access_enable;
    wire next_fifo_enable = wr_fctrl ? PWDATA[CTRL_FIFO_EN] : fifo_enable;

    // A toggle of test access drops both FIFO contents
    wire ta_toggle = next_fifo_test_access_enable != fifo_test_access_enable;
    // Changing FIFO mode also empties them, since capacity changes under the pointers
    wire fe_toggle = next_fifo_enable != fifo_enable;
    wire flush     = ta_toggle || fe_toggle;

    // Holding register mode when FIFOs are off
    wire single = !fifo_enable;

    // Data movement; test access takes the FIFOs away from the serial side
    wire test_on   = fifo_test_access_enable;
    wire host_rx_pop  = rd_done && hit_data;
    wire host_tx_push = wr_done && hit_data;
    wire test_wr   = wr_done && hit_test_dat && test_on;
    wire test_rd   = rd_done && hit_test_dat && test_on;

    wire rx_push   = (RX_PUSH && !test_on) || test_wr;
    wire [DATA_W-1:0] rx_din = test_wr ? PWDATA[DATA_W-1:0] : RX_DATA;
    wire rx_pop    = host_rx_pop;
    wire tx_push   = host_tx_push;
    wire tx_pop    = (TX_POP && !test_on) || test_rd;

    ufs_fifo u_rx_fifo (
        .clk    (CLOCK),
        .rst    (RST),
        .flush  (flush),
        .single (single),
        .push   (rx_push),
        .din    (rx_din),
        .pop    (rx_pop),
        .dout   (rx_head),
        .level  (rx_level),
        .full   (rx_full),
        .empty  (rx_empty)
    );

    ufs_fifo u_tx_fifo (
        .clk    (CLOCK),
        .rst    (RST),
        .flush  (flush),
        .single (single),
        .push   (tx_push),
        .din    (PWDATA[DATA_W-1:0]),
        .pop    (tx_pop),
        .dout   (tx_head),
        .level  (tx_level),
        .full   (tx_full),
        .empty  (tx_empty)
    );

    // Status flags
    wire rx_full_flag         = rx_full;
    wire rx_fifo_has_data_flag = !rx_empty;
    wire tx_fifo_empty_flag   = tx_empty;
    wire tx_fifo_has_space_flag = !tx_full;

    // RX_ACTIVE rises only once the receiver has checked the start bit mid-bit,
    // so an arriving start bit can still read as idle
    wire busy_raw = TX_ACTIVE || RX_ACTIVE
                 || !tx_empty || !rx_empty;

    ufs_busy_delay u_busy (
        .clk      (CLOCK),
        .rst      (RST),
        .enable   (SERIAL_CLK_EN),
        .busy_in  (busy_raw),
        .busy_out (busy)
    );

    wire [15:0] status_val = {11'h000,
                              rx_full_flag,
                              rx_fifo_has_data_flag,
                              tx_fifo_empty_flag,
                              tx_fifo_has_space_flag,
                              busy};

    // Interrupt events are rising edges of the flags
    wire [EV_W-1:0] events;
    assign events[EV_RX_DATA]  = rx_fifo_has_data_flag && !prev_rx_data;
    assign events[EV_RX_FULL]  = rx_full_flag && !prev_rx_full;
    assign events[EV_TX_EMPTY] = tx_fifo_empty_flag && !prev_tx_empty;

    wire [EV_W-1:0] clr_mask = wr_irq_clr ? PWDATA[EV_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire [EV_W-1:0] next_irq_status = (irq_status & ~clr_mask) | events;
    wire [EV_W-1:0] next_irq_enable = wr_irq_en ? PWDATA[EV_W-1:0] : irq_enable;
    wire            next_irq = |(next_irq_status & next_irq_enable);

    // Read mux
    wire [31:0] rd_data =
          hit_data     ? ufs_word({8'h00, rx_empty ? 8'h00 : rx_head})
        : hit_fctrl    ? ufs_word({15'h0000, fifo_enable})
        : hit_taccess  ? ufs_word({15'h0000, fifo_test_access_enable})
        : hit_status   ? ufs_word(status_val)
        : hit_tx_lvl   ? ufs_word(ufs_lvl16(tx_level))
        : hit_rx_lvl   ? ufs_word(ufs_lvl16(rx_level))
        : hit_test_dat ? ufs_word({8'h00, (test_on && !tx_empty) ? tx_head : 8'h00})
        : hit_irq_stat ? ufs_word({13'h0000, irq_status})
        : hit_irq_en   ? ufs_word({13'h0000, irq_enable})
        : 32'h00000000;

    // Bus answer: no wait state; ready and read data come from flops loaded in the setup phase
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= setup_phase;
            PSLVERR <= setup_phase && bad_access;
            PRDATA  <= (setup_phase && !PWRITE) ? rd_data : 32'h00000000;
        end
    end

    // Control registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            fifo_test_access_enable <= TA_RESET;
            fifo_enable             <= CTRL_RESET;
        end else begin
            fifo_test_access_enable <= next_fifo_test_access_enable;
            fifo_enable             <= next_fifo_enable;
        end
    end

    // Interrupt state
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            irq_status    <= EV_RESET;
            irq_enable    <= EV_RESET;
            prev_rx_data  <= 1'b0;
            prev_rx_full  <= 1'b0;
            prev_tx_empty <= 1'b1;
            IRQ           <= 1'b0;
        end else begin
            irq_status    <= next_irq_status;
            irq_enable    <= next_irq_enable;
            prev_rx_data  <= rx_fifo_has_data_flag;
            prev_rx_full  <= rx_full_flag;
            prev_tx_empty <= tx_fifo_empty_flag;
            IRQ           <= next_irq;
        end
    end

    // Transmit head is registered, so the engine sees it one cycle late
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            TX_DATA  <= '0;
            TX_VALID <= 1'b0;
        end else begin
            // Empty FIFO shows zero, never a stale or unwritten entry
            TX_DATA  <= tx_empty ? '0 : tx_head;
            TX_VALID <= !tx_empty && !test_on && !(TX_POP && !test_on);
        end
    end
endmodule : ufs_uart_status

// ===== hdl/ufs_pkg.sv
// Package for the UART FIFO status and test-access block
// Assumes a 32-bit APB with byte addresses as printed
package ufs_pkg;
    localparam int          DATA_W        = 8;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          LVL_W         = 5;
    localparam int          BUSY_STAGES   = 3;
    localparam logic        FIFO_ACCESS   = 1'b1;
    localparam logic        SERIAL_CLK_EN = 1'b0;
    localparam logic [31:0] ADDR_DATA     = 32'h50001100;
    localparam logic [31:0] ADDR_FCTRL    = 32'h50001108;
    localparam logic [31:0] ADDR_TACCESS  = 32'h50001170;
    localparam logic [31:0] ADDR_STATUS   = 32'h5000117c;
    localparam logic [31:0] ADDR_TX_LVL   = 32'h50001180;
    localparam logic [31:0] ADDR_RX_LVL   = 32'h50001184;
    localparam logic [31:0] ADDR_TEST_DAT = 32'h500011a0;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h500011a4;
    localparam logic [31:0] ADDR_IRQ_CLR  = 32'h500011a8;
    localparam logic [31:0] ADDR_IRQ_EN   = 32'h500011ac;
    localparam int          ST_BUSY       = 0;
    localparam int          ST_TX_SPACE   = 1;
    localparam int          ST_TX_EMPTY   = 2;
    localparam int          ST_RX_DATA    = 3;
    localparam int          ST_RX_FULL    = 4;
    localparam int          CTRL_FIFO_EN  = 0;
    localparam int          TA_EN         = 0;
    localparam int          EV_RX_DATA    = 0;
    localparam int          EV_RX_FULL    = 1;
    localparam int          EV_TX_EMPTY   = 2;
    localparam int          EV_W          = 3;
    localparam logic        TA_RESET      = 1'b0;
    localparam logic        CTRL_RESET    = 1'b0;
    localparam logic [2:0]  EV_RESET      = 3'h0;

    typedef logic [LVL_W-1:0] ufs_lvl_t;

    function automatic logic [31:0] ufs_word(input logic [15:0] v);
        ufs_word = {16'h0000, v};
    endfunction : ufs_word

    function automatic logic [15:0] ufs_lvl16(input ufs_lvl_t l);
        ufs_lvl16 = {{(16-LVL_W){1'b0}}, l};
    endfunction : ufs_lvl16
endpackage : ufs_pkg

// ===== hdl/ufs_fifo.sv
// Byte FIFO with level count, shrinkable to one holding register
// Assumes pushes when full and pops when empty are dropped by it
`timescale 1ns/1ps
module ufs_fifo
    import ufs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              flush,
    input  wire logic              single,
    input  wire logic              push,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic              pop,
    output logic      [DATA_W-1:0] dout,
    output ufs_lvl_t               level,
    output logic                   full,
    output logic                   empty
);
    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic [LVL_W-2:0]  wr_ptr;
    logic [LVL_W-2:0]  rd_ptr;
    wire               do_push = push && !full;
    wire               do_pop  = pop && !empty;
    wire ufs_lvl_t     cap     = single ? ufs_lvl_t'(1) : ufs_lvl_t'(FIFO_DEPTH);

    assign full  = (level >= cap);
    assign empty = (level == '0);
    assign dout  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end

    // Flush clears only the control portion; stored bytes are left stale
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            wr_ptr <= wr_ptr + (LVL_W-1)'(do_push);
            rd_ptr <= rd_ptr + (LVL_W-1)'(do_pop);
            level  <= level + ufs_lvl_t'(do_push) - ufs_lvl_t'(do_pop);
        end
    end
endmodule : ufs_fifo

// ===== hdl/ufs_busy_delay.sv
// Delays the rising edge of the busy indication by a number of stages
// Assumes a single clock; the falling edge passes at once
`timescale 1ns/1ps
module ufs_busy_delay
    import ufs_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic busy_in,
    output logic      busy_out
);
    logic [BUSY_STAGES-1:0] shift;

    always_ff @(posedge clk) begin
        if (rst || !busy_in) begin
            shift <= '0;
        end else begin
            shift <= {shift[BUSY_STAGES-2:0], 1'b1};
        end
    end

    assign busy_out = busy_in && (!enable || shift[BUSY_STAGES-1]);
endmodule : ufs_busy_delay

// ===== verification/ufs_uart_status_asserts.sv
// Checker of APB answers and status flag consistency
// Assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module ufs_uart_status_asserts
    import ufs_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence rd_s(logic [31:0] a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    sequence wr_s(logic [31:0] a);
        PSEL && !PENABLE && PWRITE && PADDR == a;
    endsequence
    ready_once_a: assert property (
        PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("ready not one cycle");
    err_ready_a: assert property (
        PSLVERR |-> PREADY) else $error("error without ready");
    status_ro_a: assert property (
        wr_s(ADDR_STATUS) |=> PSLVERR) else $error("status write accepted");
    status_rsvd_a: assert property (
        rd_s(ADDR_STATUS) |=> PRDATA[31:5] == 0 && !PSLVERR) else $error("status reserved");
    rx_flags_a: assert property (
        rd_s(ADDR_STATUS) |=> !PRDATA[ST_RX_FULL] || PRDATA[ST_RX_DATA]) else $error("rx flags");
    tx_flags_a: assert property (
        rd_s(ADDR_STATUS) |=> PRDATA[ST_TX_SPACE] || !PRDATA[ST_TX_EMPTY]) else $error("tx flags");
    tx_range_a: assert property (
        rd_s(ADDR_TX_LVL) |=> PRDATA <= FIFO_DEPTH) else $error("tx level range");
    rx_range_a: assert property (
        rd_s(ADDR_RX_LVL) |=> PRDATA <= FIFO_DEPTH) else $error("rx level range");
    test_rsvd_a: assert property (
        rd_s(ADDR_TACCESS) |=> PRDATA[31:1] == 0) else $error("test access reserved");
endmodule : ufs_uart_status_asserts

// ===== verification/ufs_far_end.sv
// Remote serial engine model: delivers received bytes, takes bytes to send
// Assumes the block samples its strobes at the rising edge of CLOCK
`timescale 1ns/1ps
module ufs_far_end
    import ufs_pkg::*;
(
    input  wire logic              CLOCK,
    output logic                   RX_PUSH,
    output logic      [DATA_W-1:0] RX_DATA,
    output logic                   RX_ACTIVE,
    output logic                   TX_POP,
    output logic                   TX_ACTIVE,
    input  wire logic [DATA_W-1:0] TX_DATA,
    input  wire logic              TX_VALID
);
    initial begin
        RX_PUSH   = 1'b0;
        RX_DATA   = 8'h5a;
        RX_ACTIVE = 1'b0;
        TX_POP    = 1'b0;
        TX_ACTIVE = 1'b0;
    end
    // Data line shows junk after the strobe so a stale byte never passes
    task automatic send(input logic [DATA_W-1:0] b, input int gap);
        @(posedge CLOCK);
        RX_ACTIVE <= 1'b1;
        repeat (gap) @(posedge CLOCK);
        RX_PUSH <= 1'b1;
        RX_DATA <= b;
        @(posedge CLOCK);
        RX_PUSH   <= 1'b0;
        RX_ACTIVE <= 1'b0;
        RX_DATA   <= ~b;
    endtask : send
    // Never pops twice in a row: waits for the offer each time
    task automatic take(output logic [DATA_W-1:0] b, output logic ok);
        ok = 1'b0;
        b  = '0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge CLOCK);
            ok = (TX_VALID === 1'b1);
            b  = TX_DATA;
        end
        if (ok) begin
            @(posedge CLOCK);
            TX_POP    <= 1'b1;
            TX_ACTIVE <= 1'b1;
            @(posedge CLOCK);
            TX_POP <= 1'b0;
            repeat (4) @(posedge CLOCK);
            TX_ACTIVE <= 1'b0;
        end
    endtask : take
endmodule : ufs_far_end

// ===== verification/tb.sv
// Testbench: APB master, remote serial model and checker binding
// Assumes the remote model gives strobes on the same clock as the block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import ufs_pkg::*;
    logic              CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
    logic [31:0]       PADDR, PWDATA, PRDATA, rd;
    logic              RX_PUSH, RX_ACTIVE, TX_POP, TX_ACTIVE, TX_VALID, er, ok;
    logic [DATA_W-1:0] RX_DATA, TX_DATA, b;
    int                errors, comparisons;
    ufs_uart_status i_dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RX_PUSH(RX_PUSH), .RX_DATA(RX_DATA), .RX_ACTIVE(RX_ACTIVE),
        .TX_POP(TX_POP), .TX_ACTIVE(TX_ACTIVE), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .IRQ(IRQ));
    ufs_far_end i_far (.CLOCK(CLOCK), .RX_PUSH(RX_PUSH), .RX_DATA(RX_DATA),
        .RX_ACTIVE(RX_ACTIVE), .TX_POP(TX_POP), .TX_ACTIVE(TX_ACTIVE), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID));
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    task automatic stop_test;
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Request held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        // Read at the edge itself, so values are those held before it
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1) begin
            errors++;
            stop_test();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [31:0] a, e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask : rdc
    task automatic t_reset;
        rdc(ADDR_STATUS, 32'h6);
        rdc(ADDR_TX_LVL, 32'h0);
        rdc(ADDR_RX_LVL, 32'h0);
        rdc(ADDR_TACCESS, 32'h0);
        wr(ADDR_STATUS, 32'hffff);
        `CHK("status write error", 1'b1, er)
        apb(1'b0, 32'h5000110c, 32'h0);
        `CHK("unmapped error", 1'b1, er)
        rdc(ADDR_STATUS, 32'h6);
    endtask : t_reset
    // Single holding register mode: activity flag, then held data
    task automatic t_busy;
        fork
            i_far.send(8'h3c, 12);
            begin
                repeat (5) @(posedge CLOCK);
                rdc(ADDR_STATUS, 32'h7);
            end
        join
        rdc(ADDR_STATUS, 32'h1f);
        rdc(ADDR_DATA, 32'h3c);
        rdc(ADDR_STATUS, 32'h6);
    endtask : t_busy
    task automatic t_rx;
        wr(ADDR_FCTRL, 32'h1);
        for (int i = 0; i < 17; i++) begin
            i_far.send(8'(i), 1);
        end
        rdc(ADDR_RX_LVL, 32'd16);
        rdc(ADDR_STATUS, 32'h1f);
        rdc(ADDR_DATA, 32'h0);
        rdc(ADDR_RX_LVL, 32'd15);
        rdc(ADDR_STATUS, 32'hf);
        rdc(ADDR_IRQ_STAT, 32'h3);
        wr(ADDR_IRQ_EN, 32'h2);
        repeat (2) @(negedge CLOCK);
        `CHK("irq raised", 1'b1, IRQ)
        wr(ADDR_IRQ_EN, 32'h4);
        repeat (2) @(negedge CLOCK);
        `CHK("irq masked", 1'b0, IRQ)
        wr(ADDR_IRQ_CLR, 32'h3);
        rdc(ADDR_IRQ_STAT, 32'h0);
    endtask : t_rx
    task automatic t_tx;
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_DATA, 32'(160 + i));
        end
        rdc(ADDR_TX_LVL, 32'd16);
        rdc(ADDR_STATUS, 32'h9);
        i_far.take(b, ok);
        `CHK("tx byte", 9'h1a0, {ok, b})
        rdc(ADDR_TX_LVL, 32'd15);
        rdc(ADDR_STATUS, 32'hb);
    endtask : t_tx
    task automatic t_test;
        wr(ADDR_TACCESS, 32'h1);
        rdc(ADDR_TACCESS, 32'h1);
        rdc(ADDR_RX_LVL, 32'h0);
        rdc(ADDR_TX_LVL, 32'h0);
        `CHK("irq tx flush", 1'b1, IRQ)
        wr(ADDR_TEST_DAT, 32'ha5);
        wr(ADDR_DATA, 32'h77);
        rdc(ADDR_RX_LVL, 32'h1);
        rdc(ADDR_TEST_DAT, 32'h77);
        rdc(ADDR_DATA, 32'ha5);
        wr(ADDR_TEST_DAT, 32'h5a);
        wr(ADDR_TACCESS, 32'h0);
        rdc(ADDR_RX_LVL, 32'h0);
        wr(ADDR_FCTRL, 32'h0);
        wr(ADDR_TACCESS, 32'h1);
        wr(ADDR_TEST_DAT, 32'h11);
        wr(ADDR_DATA, 32'h22);
        rdc(ADDR_STATUS, 32'h19);
        rdc(ADDR_TEST_DAT, 32'h22);
        rdc(ADDR_DATA, 32'h11);
    endtask : t_test
    initial begin
        errors      = 0;
        comparisons = 0;
        RST         = 1'b1;
        PSEL        = 1'b0;
        PENABLE     = 1'b0;
        PWRITE      = 1'b0;
        PADDR       = 32'h0;
        PWDATA      = 32'h0;
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        t_reset();
        t_busy();
        t_rx();
        t_tx();
        t_test();
        stop_test();
    end
endmodule : tb
bind ufs_uart_status ufs_uart_status_asserts i_chk (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
